// ### logic/tlic_pin_change.sv
`default_nettype none
module tlic_pin_change
  import tlic_pkg::*;
(
  input wire logic mclk,       // System clock
  input wire logic rst_n,      // Synchronous reset, active low
  tlic_chg_if.unit port        // Pins, flags and software access
);

  logic [NPINS-1:0] prev;
  logic armed;
  logic [NPINS-1:0] next_prev;
  logic next_armed;
  logic [NPINS-1:0] next_flags;

  // Toggle on any pin sets its flag; a toggle beats a clearing write
  always_comb begin
    next_prev = port.pins;
    next_armed = 1'b1;
    next_flags = port.wr_en ? port.wr_data : port.flags;
    // The first sample after reset has no history, so no change counts
    if (armed) begin
      next_flags = next_flags | (port.pins ^ prev);
    end
  end

  // Registers only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev <= '0;
      armed <= 1'b0;
      port.flags <= '0;
    end else begin
      prev <= next_prev;
      armed <= next_armed;
      port.flags <= next_flags;
    end
  end

  // Summary clears only once every pin flag is clear
  assign port.summary = |port.flags; // R22

endmodule
`default_nettype wire

// ### logic/tlic_top.sv
// Function
// R1: Priority mode: high to 0008h, low 0018h
// R2: High request preempts running low routine
// R3: Every source has flag, enable, priority
// R4: Priority mode off ignores per-source priorities
// R5: Compat: peripherals need peripheral and global enable
// R6: Compat: global enable gates all, peripherals included
// R7: Compat: every interrupt vectors to 0008h
// R8: Priority: global/high enables high-priority sources
// R9: Priority: global/high clear blocks every source
// R10: Priority: low sources need low and high enables
// R11: Flag, enable, global all set: vector
// R12: Acceptance clears the enable of that level
// R13: No low request taken during high routine
// R14: Vector: push return address, load vector
// R15: Return sets enable of exited level again
// R16: External event to vector: three-four cycles
// R17: Flags set regardless of any enable
// R18: Software clears flags before re-enabling
// R19: Software avoids memory moves on control registers
// R20: Main control: enables bits 7..3, reset zero
// R21: Timer and line flags stay until cleared
// R22: Pin-change flag read only, per-pin cleared
// R23: Line edge select: one rising, zero falling
// R24: Simultaneous high and low: high first
// R25: Eligibility re-evaluated every instruction cycle
//
// Chosen here: the register addresses and the APB register port.
`default_nettype none
module tlic_top
  import tlic_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic mclk,                  // 10 MHz system clock
  input wire logic rst_n,                 // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] paddr,    // APB address
  input wire logic psel,                  // APB select
  input wire logic penable,               // APB access phase
  input wire logic pwrite,                // APB write
  input wire logic [31:0] pwdata,         // APB write data
  output logic [31:0] prdata,             // APB read data
  output logic pready,                    // APB ready
  output logic pslverr,                   // APB error, unmapped address
  input wire logic timer0_overflow,       // Timer 0 overflow pulse
  input wire logic ext_line0,             // External line 0 level
  input wire logic [NPINS-1:0] change_pins,    // Change-monitored pins
  input wire logic [NUM_PERIPH-1:0] periph_event, // Peripheral events
  input wire logic return_from_irq_instr, // Core executes return
  output logic vec_req,                   // Push return address, jump
  output logic [15:0] vec_addr,           // Vector address
  output logic vec_high                   // Vector is of high level
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int TW = $clog2(TCY_CLKS + 1);
  localparam logic [TW-1:0] TCY_LAST = TW'(TCY_CLKS - 1);
  localparam logic [1:0] WAIT_LAST = 2'(WAIT_TCY - 1);

  logic [TW-1:0] tcy_cnt, next_tcy_cnt;
  logic tick;
  logic [7:3] ctrl, next_ctrl;
  logic t0f, next_t0f;
  logic e0f, next_e0f;
  logic [CFG_W-1:0] cfg, next_cfg;
  logic [NUM_PERIPH-1:0] pflag, next_pflag;
  logic [NUM_PERIPH-1:0] pen, next_pen;
  logic [NUM_PERIPH-1:0] ppri, next_ppri;
  logic in_high, next_in_high;
  logic in_low, next_in_low;
  logic e0_prev, next_e0_prev;
  logic e0_armed, next_e0_armed;
  logic e0_edge;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [ADDR_W-1:0] waddr;
  logic wr, rd_setup;
  tlic_state_t state, next_state;
  logic [1:0] wait_cnt, next_wait_cnt;
  logic next_vec_req, next_vec_high;
  logic [15:0] next_vec_addr;
  logic accept_hi, accept_lo;
  logic [NSRC-1:0] src_flag, src_en, src_pri;
  logic [1:0] req;

  tlic_chg_if #(.W(NPINS)) chg_if ();

  // ****************************************
  // Functions
  // ****************************************

  // Address decode for the error answer; the read path decodes the address on its own
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a == ADDR_W'(OFF_MAIN)) begin
      hit = 1'b1;
    end else if (a == ADDR_W'(OFF_CFG)) begin
      hit = 1'b1;
    end else if (a == ADDR_W'(OFF_PFLAG)) begin
      hit = 1'b1;
    end else if (a == ADDR_W'(OFF_PEN)) begin
      hit = 1'b1;
    end else if (a == ADDR_W'(OFF_PPRI)) begin
      hit = 1'b1;
    end else if (a == ADDR_W'(OFF_PINFLG)) begin
      hit = 1'b1;
    end else if (a == ADDR_W'(OFF_STAT)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Returns {high request, low request} for the current state
  function automatic logic [1:0] eligible(
    input logic [NSRC-1:0] flag,
    input logic [NSRC-1:0] en,
    input logic [NSRC-1:0] pri,
    input logic pme,
    input logic ghe,
    input logic ple,
    input logic busy_high
  );
    logic [NSRC-1:0] act;
    logic [1:0] r;
    act = flag & en; // R3
    if (!pme) begin
      // Single level, reported as high; priority bits unused
      r[1] = ghe & ((|act[NCORE-1:0]) | (ple & (|act[NSRC-1:NCORE]))); // R4 R5 R6
      r[0] = 1'b0;
    end else begin
      r[1] = ghe & (|(act & pri)); // R8 R9
      r[0] = ghe & ple & ~busy_high & (|(act & ~pri)); // R10 R13
    end
    return r;
  endfunction

  // ****************************************
  // Instruction cycle divider
  // ****************************************

  // One tick per instruction cycle paces the whole response
  always_comb begin
    next_tcy_cnt = (tcy_cnt == TCY_LAST) ? '0 : tcy_cnt + TW'(1);
  end
  assign tick = (tcy_cnt == TCY_LAST);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tcy_cnt <= '0;
    end else begin
      tcy_cnt <= next_tcy_cnt;
    end
  end

  // ****************************************
  // Source vectors and pin-change unit
  // ****************************************
  assign src_flag = {pflag, chg_if.summary, e0f, t0f};
  assign src_en = {pen, ctrl[MAIN_PCIE], ctrl[MAIN_E0IE], ctrl[MAIN_T0IE]};
  assign src_pri = {ppri, cfg[CFG_PCP], cfg[CFG_E0P], cfg[CFG_T0P]};
  assign req = eligible(src_flag, src_en, src_pri, cfg[CFG_PME],
                        ctrl[MAIN_GHE], ctrl[MAIN_PLE], in_high);

  assign chg_if.pins = change_pins;
  assign chg_if.wr_en = wr && (waddr == ADDR_W'(OFF_PINFLG));
  assign chg_if.wr_data = pwdata[NPINS-1:0];

  tlic_pin_change u_chg (
    .mclk(mclk),
    .rst_n(rst_n),
    .port(chg_if.unit)
  );

  // Edge on line 0 in the selected direction
  assign e0_edge = e0_armed &
    (cfg[CFG_EDGE0] ? (ext_line0 & ~e0_prev) : (~ext_line0 & e0_prev)); // R23

  // ****************************************
  // APB slave
  // ****************************************

  // One wait state: read data is registered on the same edge that raises pready
  assign waddr = paddr;
  assign rd_setup = psel & penable & ~pready;
  assign wr = psel & penable & pready & pwrite;

  always_comb begin
    next_pready = rd_setup;
    next_pslverr = rd_setup & ~is_mapped(paddr);
    next_prdata = prdata;
    if (rd_setup) begin
      next_prdata = '0;
      if (pwrite) begin
        next_prdata = '0;
      end else if (paddr == ADDR_W'(OFF_MAIN)) begin
        next_prdata[7:0] = {ctrl, t0f, e0f, chg_if.summary}; // R20
      end else if (paddr == ADDR_W'(OFF_CFG)) begin
        next_prdata[CFG_W-1:0] = cfg;
      end else if (paddr == ADDR_W'(OFF_PFLAG)) begin
        next_prdata[NUM_PERIPH-1:0] = pflag;
      end else if (paddr == ADDR_W'(OFF_PEN)) begin
        next_prdata[NUM_PERIPH-1:0] = pen;
      end else if (paddr == ADDR_W'(OFF_PPRI)) begin
        next_prdata[NUM_PERIPH-1:0] = ppri;
      end else if (paddr == ADDR_W'(OFF_PINFLG)) begin
        next_prdata[NPINS-1:0] = chg_if.flags;
      end else if (paddr == ADDR_W'(OFF_STAT)) begin
        next_prdata[2:0] = {state == ST_WAIT, in_low, in_high};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ****************************************
  // Response sequencer
  // ****************************************

  // Sample at a tick, wait, then re-check so a cleared flag aborts
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    accept_hi = 1'b0;
    accept_lo = 1'b0;
    case (state)
      ST_IDLE: begin
        if (tick && (|req)) begin // R11 R25
          next_state = ST_WAIT;
          next_wait_cnt = '0;
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (wait_cnt == WAIT_LAST) begin // R16
            next_state = ST_IDLE;
            // Fresh evaluation; high wins a tie
            if (req[1]) begin // R24 R25 R2
              accept_hi = 1'b1;
            end else if (req[0]) begin
              accept_lo = 1'b1;
            end
          end else begin
            next_wait_cnt = wait_cnt + 2'h1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_vec_req = accept_hi | accept_lo; // R14
    next_vec_high = accept_hi;
    next_vec_addr = vec_addr;
    if (accept_hi) begin
      next_vec_addr = VEC_HIGH; // R1 R7
    end else if (accept_lo) begin
      next_vec_addr = VEC_LOW; // R1
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      wait_cnt <= '0;
      vec_req <= 1'b0;
      vec_high <= 1'b0;
      vec_addr <= '0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      vec_req <= next_vec_req;
      vec_high <= next_vec_high;
      vec_addr <= next_vec_addr;
    end
  end

  // ****************************************
  // Control and flag registers
  // ****************************************

  // Software write first, then hardware effects; events always win
  always_comb begin
    next_ctrl = ctrl;
    next_t0f = t0f;
    next_e0f = e0f;
    next_cfg = cfg;
    next_pflag = pflag;
    next_pen = pen;
    next_ppri = ppri;
    next_in_high = in_high;
    next_in_low = in_low;
    next_e0_prev = ext_line0;
    next_e0_armed = 1'b1;
    if (wr && (waddr == ADDR_W'(OFF_MAIN))) begin
      next_ctrl = pwdata[7:3]; // R20
      next_t0f = pwdata[MAIN_T0F];
      next_e0f = pwdata[MAIN_E0F];
    end else if (wr && (waddr == ADDR_W'(OFF_CFG))) begin
      next_cfg = pwdata[CFG_W-1:0];
    end else if (wr && (waddr == ADDR_W'(OFF_PFLAG))) begin
      next_pflag = pwdata[NUM_PERIPH-1:0];
    end else if (wr && (waddr == ADDR_W'(OFF_PEN))) begin
      next_pen = pwdata[NUM_PERIPH-1:0];
    end else if (wr && (waddr == ADDR_W'(OFF_PPRI))) begin
      next_ppri = pwdata[NUM_PERIPH-1:0];
    end
    // Sticky flags, set whatever the enables say
    next_t0f = next_t0f | timer0_overflow; // R17 R21
    next_e0f = next_e0f | e0_edge; // R17 R21
    next_pflag = next_pflag | periph_event; // R17
    // Return reopens the level being left, innermost first
    if (return_from_irq_instr) begin
      if (in_high) begin
        next_in_high = 1'b0;
        next_ctrl[MAIN_GHE] = 1'b1; // R15
      end else if (in_low) begin
        next_in_low = 1'b0;
        next_ctrl[MAIN_PLE] = 1'b1; // R15
      end
    end
    // Acceptance closes its own level; compat always uses the global bit
    if (accept_hi) begin
      next_in_high = 1'b1;
      next_ctrl[MAIN_GHE] = 1'b0; // R12
    end else if (accept_lo) begin
      next_in_low = 1'b1;
      next_ctrl[MAIN_PLE] = 1'b0; // R12
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= MAIN_RESET[7:3]; // R20
      t0f <= MAIN_RESET[MAIN_T0F];
      e0f <= MAIN_RESET[MAIN_E0F];
      cfg <= CFG_RESET;
      pflag <= PREG_RESET;
      pen <= PREG_RESET;
      ppri <= PREG_RESET;
      in_high <= 1'b0;
      in_low <= 1'b0;
      e0_prev <= 1'b0;
      e0_armed <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      t0f <= next_t0f;
      e0f <= next_e0f;
      cfg <= next_cfg;
      pflag <= next_pflag;
      pen <= next_pen;
      ppri <= next_ppri;
      in_high <= next_in_high;
      in_low <= next_in_low;
      e0_prev <= next_e0_prev;
      e0_armed <= next_e0_armed;
    end
  end

endmodule
`default_nettype wire

// ### shared/tlic_chg_if.sv
`default_nettype none
interface tlic_chg_if #(parameter int W = 8);
  logic [W-1:0] pins;     // Monitored pin levels
  logic wr_en;            // Software write of the per-pin flags
  logic [W-1:0] wr_data;  // Value written
  logic [W-1:0] flags;    // per_pin_change_flags
  logic summary;          // pin_change_summary_flag

  modport ctl (output pins, output wr_en, output wr_data,
               input flags, input summary);
  modport unit (input pins, input wr_en, input wr_data,
                output flags, output summary);
endinterface
`default_nettype wire

// ### shared/tlic_pkg.sv
`default_nettype none
package tlic_pkg;

  // ****************************************
  // Register map, APB byte addresses
  // ****************************************
  localparam logic [7:0] OFF_MAIN = 8'h00;   // interrupt_main_control
  localparam logic [7:0] OFF_CFG = 8'h04;    // Mode, edge and core priorities
  localparam logic [7:0] OFF_PFLAG = 8'h08;  // Peripheral flags
  localparam logic [7:0] OFF_PEN = 8'h0c;    // Peripheral enables
  localparam logic [7:0] OFF_PPRI = 8'h10;   // Peripheral priorities
  localparam logic [7:0] OFF_PINFLG = 8'h14; // Per-pin change flags
  localparam logic [7:0] OFF_STAT = 8'h18;   // Service state, read only

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MAIN_GHE = 7;
  localparam int MAIN_PLE = 6;
  localparam int MAIN_T0IE = 5;
  localparam int MAIN_E0IE = 4;
  localparam int MAIN_PCIE = 3;
  localparam int MAIN_T0F = 2;
  localparam int MAIN_E0F = 1;
  localparam int MAIN_PCF = 0;
  localparam int CFG_PME = 0;
  localparam int CFG_EDGE0 = 1;
  localparam int CFG_T0P = 2;
  localparam int CFG_E0P = 3;
  localparam int CFG_PCP = 4;
  localparam int CFG_W = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] MAIN_RESET = 8'h00;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h02; // Rising edge by default
  localparam logic [7:0] PREG_RESET = 8'h00;

  // ****************************************
  // Sources and vectors
  // ****************************************
  localparam int NUM_PERIPH = 8;
  localparam int NCORE = 3;                 // Timer 0, line 0, pin change
  localparam int NSRC = NCORE + NUM_PERIPH;
  localparam int NPINS = 8;
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW = 16'h0018;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 100;
  localparam int TCY_NS = 400;              // One instruction cycle
  localparam int TCY_CLKS = (TCY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAIT_TCY = 3;              // Cycles from sampling to vector

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } tlic_state_t;

endpackage
`default_nettype wire

// ### sim/tlic_core_model.sv
`default_nettype none
module tlic_core_model
  import tlic_pkg::*;
(
  input wire logic mclk,              // Clock
  input wire logic rst_n,             // Reset, active low
  input wire logic vec_req,           // Vector from controller
  input wire logic [15:0] vec_addr,   // Vector target
  input wire logic ret_go,            // Bench asks for a return
  output logic return_from_irq_instr, // Return executed
  output logic [15:0] pc,             // Program counter
  output logic [2:0] depth            // Stack depth
);
  logic [15:0] stack [0:7];

  // Push and jump on a vector; a return pops, only when something is on
  // the stack, so a stray bench request cannot underflow
  always_ff @(posedge mclk) begin
    return_from_irq_instr <= 1'b0;
    if (!rst_n) begin
      pc <= 16'h0100;
      depth <= 3'h0;
    end else if (vec_req) begin
      stack[depth] <= pc + 16'h0002;
      depth <= depth + 3'h1;
      pc <= vec_addr;
    end else if (ret_go && depth != 3'h0) begin
      return_from_irq_instr <= 1'b1;
      depth <= depth - 3'h1;
      pc <= stack[depth-3'h1];
    end
  end
endmodule
`default_nettype wire

// ### sim/tlic_sva.sv
`default_nettype none
module tlic_sva
  import tlic_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic mclk,               // Clock
  input wire logic rst_n,              // Reset, active low
  input wire logic [ADDR_W-1:0] paddr, // APB address
  input wire logic psel,               // APB select
  input wire logic penable,            // APB access
  input wire logic pwrite,             // APB write
  input wire logic [31:0] prdata,      // APB read data
  input wire logic pready,             // APB ready
  input wire logic pslverr,            // APB error
  input wire logic vec_req,            // Vector pulse
  input wire logic [15:0] vec_addr,    // Vector address
  input wire logic vec_high            // High level taken
);
  // ****************************************
  // Properties, one clock domain
  // ****************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  vec_level_a: assert property (
    vec_req |-> vec_addr == (vec_high ? VEC_HIGH : VEC_LOW))
    else $error("vector address does not match level");
  vec_pulse_a: assert property (
    vec_req |=> !vec_req [*3])
    else $error("vector requests too close");
  vec_hold_a: assert property (
    !vec_req |-> $stable(vec_addr) && !vec_high)
    else $error("vector target moved without a request");
  ready_wait_a: assert property (
    psel && $rose(penable) |-> !pready ##1 pready)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (
    pready |-> psel && penable && $past(penable) ##1 !pready)
    else $error("ready outside access or too long");
  err_ready_a: assert property (
    pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (
    pready && paddr > OFF_STAT |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  read_upper_a: assert property (
    pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");

  // Main scenarios reached
  cover property (vec_req && vec_high);
  cover property (vec_req && !vec_high);
  cover property (pready && pslverr);
endmodule

bind tlic_top tlic_sva #(.ADDR_W(ADDR_W)) tlic_sva_inst (
  .mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .vec_req(vec_req),
  .vec_addr(vec_addr), .vec_high(vec_high)
);
`default_nettype wire

// ### sim/two_level_interrupt_controller_tb_top.sv
`default_nettype none
module two_level_interrupt_controller_tb_top
  import tlic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end

  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, t0 = 1'b0, ext0 = 1'b0, ret_go = 1'b0;
  logic [7:0] paddr = 8'h00, pins = 8'h00, pev = 8'h00, r8;
  logic [31:0] pwdata = 32'h0, prdata, er;
  logic pready, pslverr, vec_req, vec_high, ret_pulse;
  logic [15:0] vec_addr, pc;
  logic [16:0] ev_exp;
  logic [2:0] depth;
  logic [31:0] rdq[$];
  logic [16:0] vq[$];
  int n_mismatch = 0, tests_run = 0;

  // Clock, 100 ns period
  initial begin
    forever #50 mclk = ~mclk;
  end

  tlic_top tlic_top_inst (.mclk(mclk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0_overflow(t0), .ext_line0(ext0), .change_pins(pins),
    .periph_event(pev), .return_from_irq_instr(ret_pulse),
    .vec_req(vec_req), .vec_addr(vec_addr), .vec_high(vec_high));
  tlic_core_model tlic_core_model_inst (.mclk(mclk), .rst_n(rst_n),
    .vec_req(vec_req), .vec_addr(vec_addr), .ret_go(ret_go),
    .return_from_irq_instr(ret_pulse), .pc(pc), .depth(depth));

  // ****************************************
  // Bus and event tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("BAD pready exp 1 got %b", pready);
      close_out();
    end
    `CHK("pslverr", a > OFF_STAT, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so back-to-back calls never drive psel twice at once
    @(posedge mclk);
  endtask
  // Control writes are single plain bus writes, never memory moves
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Bit 0 timer pulse, bit 1 line toggle, bit 2 peripheral 0 pulse
  task automatic ev(input logic [2:0] k);
    if (k[0]) t0 <= 1'b1;
    if (k[1]) ext0 <= ~ext0;
    if (k[2]) pev <= 8'h01;
    @(posedge mclk);
    // Only what was raised is lowered, so a following call never drives
    // the same pin twice in one time step
    if (k[0]) t0 <= 1'b0;
    if (k[2]) pev <= 8'h00;
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic ret();
    ret_go <= 1'b1;
    @(posedge mclk);
    ret_go <= 1'b0;
    quiet(2);
  endtask
  // Bounded wait for the watcher to consume the queued vectors
  task automatic wait_vec(input logic lat_chk);
    int i;
    i = 0;
    while (vq.size() > 0 && i < 40) begin
      @(posedge mclk);
      i++;
    end
    if (vq.size() > 0) begin
      n_mismatch++;
      $display("BAD vector exp %h got none", vq[0]);
      close_out();
    end
    if (lat_chk) `CHK("latency", 1'b1, i >= 11 && i <= 18)
    quiet(1);
  endtask
  task automatic close_out();
    $display("Mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watcher: oldest note against each read answer or vector
  always @(posedge mclk) begin
    if (rst_n && pready === 1'b1 && pwrite === 1'b0 && rdq.size() > 0) begin
      er = rdq.pop_front();
      `CHK("prdata", er, prdata)
    end
    if (rst_n && vec_req === 1'b1) begin
      if (vq.size() == 0) begin
        n_mismatch++;
        $display("BAD vector exp none got %h", vec_addr);
      end else begin
        ev_exp = vq.pop_front();
        `CHK("vector", ev_exp, {vec_high, vec_addr})
      end
    end
  end

  // A hang ends in the same report
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    $display("BAD run exp end got timeout");
    close_out();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(62));
    quiet(16);
    rst_n <= 1'b1;
    quiet(1);
    rd(OFF_MAIN, 32'h0);
    rd(OFF_CFG, {27'h0, CFG_RESET});
    rd(8'h1c, 32'h0);
    ev(3'b001);
    quiet(20);
    rd(OFF_MAIN, 32'h04);
    ev(3'b010);
    quiet(8);
    rd(OFF_MAIN, 32'h06);
    wr(OFF_MAIN, 32'h0);
    wr(OFF_CFG, 32'h0);
    ev(3'b010);
    quiet(8);
    rd(OFF_MAIN, 32'h02);
    wr(OFF_MAIN, 32'h0);
    ev(3'b010);
    quiet(8);
    rd(OFF_MAIN, 32'h0);
    // Random pin toggles; summary is read only
    r8 = 8'($urandom_range(255, 1));
    pins <= r8;
    quiet(8);
    rd(OFF_PINFLG, {24'h0, r8});
    wr(OFF_MAIN, 32'h0);
    rd(OFF_MAIN, 32'h01);
    wr(OFF_PINFLG, 32'h0);
    rd(OFF_MAIN, 32'h0);
    // Compatibility mode: one vector, priorities ignored
    wr(OFF_PPRI, 32'h0);
    wr(OFF_MAIN, 32'ha0);
    vq.push_back({1'b1, VEC_HIGH});
    ev(3'b001);
    wait_vec(1'b0);
    `CHK("pc", VEC_HIGH, pc)
    rd(OFF_MAIN, 32'h24);
    wr(OFF_MAIN, 32'h20);
    ret();
    rd(OFF_MAIN, 32'ha0);
    wr(OFF_PPRI, 32'h01);
    wr(OFF_PEN, 32'h01);
    wr(OFF_MAIN, 32'h80);
    ev(3'b100);
    quiet(30);
    vq.push_back({1'b1, VEC_HIGH});
    wr(OFF_MAIN, 32'hc0);
    wait_vec(1'b0);
    wr(OFF_PFLAG, 32'h0);
    ret();
    wr(OFF_MAIN, 32'h60);
    ev(3'b001);
    quiet(30);
    // Priority mode: timer high, line and peripheral low
    wr(OFF_MAIN, 32'h0);
    wr(OFF_PPRI, 32'h0);
    wr(OFF_CFG, 32'h07);
    wr(OFF_MAIN, 32'hb0);
    ev(3'b010);
    ev(3'b010);
    quiet(30);
    wr(OFF_MAIN, 32'hf0);
    ev(3'b010);
    vq.push_back({1'b0, VEC_LOW});
    ev(3'b010);
    wait_vec(1'b1);
    vq.push_back({1'b1, VEC_HIGH});
    ev(3'b001);
    wait_vec(1'b0);
    // High routine nested inside the low one, nothing waiting
    rd(OFF_STAT, 32'h3);
    wr(OFF_MAIN, 32'hc0);
    ev(3'b100);
    quiet(30);
    vq.push_back({1'b0, VEC_LOW});
    ret();
    wait_vec(1'b0);
    wr(OFF_PFLAG, 32'h0);
    ret();
    ret();
    `CHK("depth", 3'h0, depth)
    wr(OFF_MAIN, 32'h70);
    ev(3'b101);
    quiet(30);
    wr(OFF_PFLAG, 32'h0);
    wr(OFF_MAIN, 32'hf0);
    ev(3'b010);
    vq.push_back({1'b1, VEC_HIGH});
    ev(3'b011);
    wait_vec(1'b0);
    wr(OFF_MAIN, 32'h52);
    vq.push_back({1'b0, VEC_LOW});
    ret();
    wait_vec(1'b0);
    close_out();
  end
endmodule
`default_nettype wire
